// [hsh_cfg.svh]
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the homing sequencer files
`ifndef HSH_CFG_SVH
`define HSH_CFG_SVH

`define HSH_OFS_CTRL 8'h00
`define HSH_OFS_STATUS 8'h04
`define HSH_OFS_IRQ_STAT 8'h08
`define HSH_OFS_IRQ_MASK 8'h0C
`define HSH_OFS_THRESH 8'h10
`define HSH_OFS_CONT_CUR 8'h14
`define HSH_OFS_STALL_DLY 8'h18
`define HSH_OFS_HARM_GAIN 8'h1C
`define HSH_OFS_HARM_PHASE 8'h20
`define HSH_OFS_VEL1 8'h24
`define HSH_OFS_ACC1 8'h30
`define HSH_OFS_DEC1 8'h3C
`define HSH_OFS_OFFSET 8'h48

`define HSH_CTRL_START 0
`define HSH_CTRL_INDEX 1
`define HSH_CTRL_ABORT 2
`define HSH_CTRL_STALL_EN 3

`define HSH_IRQ_DONE 0
`define HSH_IRQ_ERROR 1
`define HSH_IRQ_STALL 2

`define HSH_RST_THRESH 16'h0064
`define HSH_RST_CONT_CUR 16'h00C8
`define HSH_RST_STALL_DLY 16'h03E8
`define HSH_RST_VEL1 16'h094D
`define HSH_RST_VEL2 16'h04A6
`define HSH_RST_VEL3 16'h0077
`define HSH_RST_RATE12 16'h0257
`define HSH_RST_RATE3 16'h003C
`define HSH_RST_OFFSET 32'h000007D0

`define HSH_THRESH_MIN 16'h0001
`define HSH_STALL_DLY_MIN 16'h0001
`define HSH_STALL_DLY_MAX 16'h7D00
`define HSH_RATE_MIN 16'h0001
`define HSH_RATE_MAX 16'h7FBE
`define HSH_VEL_MIN 16'h0001
`define HSH_VEL_MAX 16'h4A67
`define HSH_PHASE_MAX 8'sh7D
`define HSH_OFFSET_MIN 32'h80000001

`define HSH_CLK_PERIOD_NS 4
`define HSH_MS_NS 1000000
`define HSH_MS_CYCLES (`HSH_MS_NS / `HSH_CLK_PERIOD_NS)
`define HSH_STEP_TIMEOUT_MS 10000

`endif

// [hsh_pkg.sv]
// types shared by the homing sequencer and its ramp generator
// assumes hsh_cfg.svh carries the numeric constants
package hsh_pkg;
  typedef logic signed [17:0] hsh_vel_t;
  typedef struct packed {
    logic [15:0] vel;
    logic [15:0] acc;
    logic [15:0] dec;
  } hsh_step_t;
  typedef enum logic [2:0] {
    HSH_IDLE = 3'b000,
    HSH_SEEK = 3'b001,
    HSH_INDEX = 3'b010,
    HSH_OFFSET = 3'b011,
    HSH_BRAKE = 3'b100
  } hsh_state_t;
  typedef struct packed {
    logic stall;
    logic error;
    logic done;
  } hsh_evt_t;
endpackage

// [hsh_ramp.sv]
// velocity ramp toward a signed target with separate accel and decel
// assumes one clock, synchronous active-high reset
`timescale 1ns/10ps
`include "hsh_cfg.svh"
module hsh_ramp #(
  parameter int TICK_CYCLES = 2500,
  parameter int SCALE_BITS = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire hsh_pkg::hsh_vel_t target,
  input wire hsh_pkg::hsh_step_t step_cfg,
  output hsh_pkg::hsh_vel_t vel,
  output logic at_target
);
  import hsh_pkg::*;

  localparam int FW = 18 + SCALE_BITS;
  logic signed [FW-1:0] fine_q, fine_d;
  logic [15:0] tick_q;
  wire tick = (tick_q == 16'(TICK_CYCLES - 1));
  wire signed [FW-1:0] goal = {target, {SCALE_BITS{1'b0}}};
  wire signed [FW-1:0] diff = goal - fine_q;
  // shrinking speed or reversing uses decel, else accel
  wire slowing = (fine_q != '0) &&
    ((goal == '0) || (goal[FW-1] != fine_q[FW-1]) ||
     (fine_q[FW-1] ? (goal > fine_q) : (goal < fine_q)));
  wire signed [FW-1:0] rate = FW'(slowing ? step_cfg.dec : step_cfg.acc);
  wire signed [FW-1:0] mag = diff[FW-1] ? -diff : diff;

  always_comb begin
    fine_d = fine_q;
    if (tick) begin
      if (mag <= rate)
        fine_d = goal;
      else if (diff[FW-1])
        fine_d = fine_q - rate; // R19
      else
        fine_d = fine_q + rate; // R19
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fine_q <= '0;
      tick_q <= 16'h0000;
    end else begin
      fine_q <= fine_d;
      tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
    end
  end

  assign vel = fine_q[FW-1:SCALE_BITS];
  assign at_target = (fine_q == goal);
endmodule

// [hsh_sequencer.sv]
// hard-stop homing sequencer with its parameter registers
// assumes a plain register port, one clock, synchronous reset
//
// Behaviour
// [R1] threshold in 0.01 A, at least 0.01 A, never above continuous current
// [R2] end stop reached when motor current reaches the threshold
// [R3] stall recovery runs the set 1..32000 ms, then a fault is raised
// [R4] harmonic gain 0..32767, used with the phase against ripple
// [R5] signed harmonic phase -125..+125, applied jointly with the gain
// [R6] per-step deceleration, 0.167 rev/s2 units, range kept
// [R7] default decelerations 100, 100 and 10 rev/s2
// [R8] signed home offset in steps, travelled after the home reference
// [R9] positive offset starts clockwise, negative counter-clockwise
// [R10] seek end stop in start direction, then optional index search
// [R11] command bit 0 hard stop only, 1 adds index search
// [R12] offset move starts once hard stop or index is reached
// [R13] step-one velocity to seek, step two offset, step three index
// [R14] host configures threshold and per-step rates before homing
// [R15] host keeps the threshold low to protect the mechanics
// [R16] per-step acceleration, defaults 100, 100 and 10 rev/s2
// [R17] per-step velocities 0.0042..80 rev/s, defaults 10, 5, 0.5
// [R18] completion reported after offset move; failed step aborts with error
// [R19] each step ramps with its own acceleration and deceleration
`timescale 1ns/10ps
`include "hsh_cfg.svh"
module hsh_sequencer #(
  parameter int MS_CYCLES = `HSH_MS_CYCLES,
  parameter int STEP_TIMEOUT_MS = `HSH_STEP_TIMEOUT_MS,
  parameter int RAMP_TICK = 2500
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [15:0] motor_current,
  input wire logic index_pulse,
  input wire logic stall_detect,
  input wire logic step_tick,
  output hsh_pkg::hsh_vel_t vel_cmd,
  output logic signed [23:0] harm_comp,
  output logic stall_fault,
  output logic homing_busy,
  output logic irq
);
  import hsh_pkg::*;

  hsh_state_t state_q, state_d, after_q, after_d;
  hsh_step_t steps_q [3];
  hsh_evt_t irq_stat_q, irq_mask_q, evt;
  logic [15:0] thresh_q, cont_cur_q, stall_dly_q;
  logic [14:0] gain_q;
  logic signed [7:0] phase_q;
  logic signed [31:0] offset_q;
  logic index_sel_q, stall_en_q, cw_q;
  logic [1:0] step_sel_q, step_sel_d;
  logic [31:0] moved_q, ms_cnt_q, to_cnt_q;
  logic [15:0] stall_ms_q;
  logic stall_flt_q, err_pend_q, err_pend_d, done_ev, err_ev;
  logic [31:0] rdata_q;
  hsh_vel_t target, ramp_vel;
  logic ramp_at;

  // write decode
  wire wr_ctrl = wr && (addr == `HSH_OFS_CTRL);
  wire wr_istat = wr && (addr == `HSH_OFS_IRQ_STAT);
  wire wr_imask = wr && (addr == `HSH_OFS_IRQ_MASK);
  wire wr_thr = wr && (addr == `HSH_OFS_THRESH);
  wire wr_cc = wr && (addr == `HSH_OFS_CONT_CUR);
  wire wr_sdly = wr && (addr == `HSH_OFS_STALL_DLY);
  wire wr_gain = wr && (addr == `HSH_OFS_HARM_GAIN);
  wire wr_phase = wr && (addr == `HSH_OFS_HARM_PHASE);
  wire wr_ofs = wr && (addr == `HSH_OFS_OFFSET);
  wire start = wr_ctrl && wdata[`HSH_CTRL_START] && (state_q == HSH_IDLE);
  wire abort = wr_ctrl && wdata[`HSH_CTRL_ABORT] && (state_q != HSH_IDLE);

  // write clamps
  wire [15:0] w16 = wdata[15:0];
  wire [15:0] thr_w = (w16 < `HSH_THRESH_MIN) ? `HSH_THRESH_MIN :
    (w16 > cont_cur_q) ? cont_cur_q : w16; // R1
  wire [15:0] sdly_w = (w16 < `HSH_STALL_DLY_MIN) ? `HSH_STALL_DLY_MIN :
    (w16 > `HSH_STALL_DLY_MAX) ? `HSH_STALL_DLY_MAX : w16; // R3
  wire [15:0] rate_w = (w16 < `HSH_RATE_MIN) ? `HSH_RATE_MIN :
    (w16 > `HSH_RATE_MAX) ? `HSH_RATE_MAX : w16; // R6
  wire [15:0] vel_w = (w16 < `HSH_VEL_MIN) ? `HSH_VEL_MIN :
    (w16 > `HSH_VEL_MAX) ? `HSH_VEL_MAX : w16; // R17
  wire signed [31:0] ws = wdata;
  wire signed [7:0] phase_w = (ws > 32'sd125) ? `HSH_PHASE_MAX :
    (ws < -32'sd125) ? -`HSH_PHASE_MAX : ws[7:0]; // R5
  wire signed [31:0] ofs_w = (wdata == 32'h80000000) ? `HSH_OFFSET_MIN
    : ws; // R8
  // threshold in force never exceeds continuous current
  wire [15:0] thr_eff = (thresh_q > cont_cur_q) ? cont_cur_q : thresh_q; // R1

  // derived sequencing terms
  wire [31:0] ofs_mag = offset_q[31] ? 32'(-offset_q) : 32'(offset_q);
  wire hit_stop = (motor_current >= thr_eff); // R2
  wire ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));
  wire timeout = (to_cnt_q >= 32'(STEP_TIMEOUT_MS)) && (state_q != HSH_IDLE)
    && (state_q != HSH_BRAKE);
  wire stall_trip = stall_en_q && stall_detect && ms_tick &&
    (stall_ms_q >= stall_dly_q - 16'h0001) && !stall_flt_q; // R3
  wire [15:0] svel = steps_q[step_sel_q].vel;
  wire hsh_vel_t svel_s = hsh_vel_t'({2'b00, svel});
  wire moving = (state_q == HSH_SEEK) || (state_q == HSH_INDEX) ||
    (state_q == HSH_OFFSET);
  // offset move heads back away from the stop
  wire fwd = (state_q == HSH_OFFSET) ? !cw_q : cw_q;

  assign target = !moving ? '0 : (fwd ? svel_s : -svel_s); // R9

  hsh_ramp #(
    .TICK_CYCLES(RAMP_TICK),
    .SCALE_BITS(8)
  ) u_ramp (
    .clk(clk),
    .rst(rst),
    .target(target),
    .step_cfg(steps_q[step_sel_q]),
    .vel(ramp_vel),
    .at_target(ramp_at)
  ); // R19

  always_comb begin
    state_d = state_q;
    after_d = after_q;
    step_sel_d = step_sel_q;
    err_pend_d = err_pend_q;
    done_ev = 1'b0;
    err_ev = 1'b0;
    if (abort || timeout || (stall_trip && state_q != HSH_IDLE)) begin
      state_d = HSH_BRAKE; // R18
      after_d = HSH_IDLE;
      err_pend_d = 1'b1;
    end else begin
      case (state_q)
        HSH_IDLE: begin
          if (start) begin
            state_d = HSH_SEEK; // R10
            step_sel_d = 2'd0; // R13
            err_pend_d = 1'b0;
          end
        end
        HSH_SEEK: begin
          if (hit_stop) begin
            state_d = HSH_BRAKE; // R2
            after_d = index_sel_q ? HSH_INDEX : HSH_OFFSET; // R11
          end
        end
        HSH_INDEX: begin
          if (index_pulse) begin
            state_d = HSH_BRAKE; // R10
            after_d = HSH_OFFSET; // R12
          end
        end
        HSH_OFFSET: begin
          if (moved_q >= ofs_mag) begin
            state_d = HSH_BRAKE; // R8
            after_d = HSH_IDLE;
          end
        end
        HSH_BRAKE: begin
          if (ramp_at) begin
            state_d = after_q;
            if (after_q == HSH_INDEX)
              step_sel_d = 2'd2; // R13
            else if (after_q == HSH_OFFSET)
              step_sel_d = 2'd1; // R13
            else begin
              done_ev = !err_pend_q; // R18
              err_ev = err_pend_q; // R18
            end
          end
        end
        default: state_d = HSH_IDLE;
      endcase
    end
  end

  assign evt.done = done_ev;
  assign evt.error = err_ev;
  assign evt.stall = stall_trip;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= HSH_IDLE;
      after_q <= HSH_IDLE;
      step_sel_q <= 2'd0;
      err_pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      after_q <= after_d;
      step_sel_q <= step_sel_d;
      err_pend_q <= err_pend_d;
    end
  end

  // offset distance, step timeout and stall delay counters
  always_ff @(posedge clk) begin
    if (rst) begin
      moved_q <= 32'h00000000;
      ms_cnt_q <= 32'h00000000;
      to_cnt_q <= 32'h00000000;
      stall_ms_q <= 16'h0000;
      stall_flt_q <= 1'b0;
    end else begin
      ms_cnt_q <= ms_tick ? 32'h00000000 : ms_cnt_q + 32'h00000001;
      if (state_q != HSH_OFFSET)
        moved_q <= 32'h00000000;
      else if (step_tick)
        moved_q <= moved_q + 32'h00000001; // R8
      if (state_d != state_q)
        to_cnt_q <= 32'h00000000;
      else if (ms_tick)
        to_cnt_q <= to_cnt_q + 32'h00000001;
      if (!stall_en_q || !stall_detect) begin
        stall_ms_q <= 16'h0000; // R3
        stall_flt_q <= 1'b0;
      end else if (ms_tick && !stall_flt_q) begin
        stall_ms_q <= stall_ms_q + 16'h0001;
        stall_flt_q <= stall_trip; // R3
      end
    end
  end

  // parameter registers
  always_ff @(posedge clk) begin
    if (rst) begin
      thresh_q <= `HSH_RST_THRESH;
      cont_cur_q <= `HSH_RST_CONT_CUR;
      stall_dly_q <= `HSH_RST_STALL_DLY;
      gain_q <= 15'h0000;
      phase_q <= 8'sh00;
      offset_q <= `HSH_RST_OFFSET;
      index_sel_q <= 1'b0;
      stall_en_q <= 1'b0;
      cw_q <= 1'b1;
      steps_q[0] <= {`HSH_RST_VEL1, `HSH_RST_RATE12, `HSH_RST_RATE12}; // R7
      steps_q[1] <= {`HSH_RST_VEL2, `HSH_RST_RATE12, `HSH_RST_RATE12}; // R16
      steps_q[2] <= {`HSH_RST_VEL3, `HSH_RST_RATE3, `HSH_RST_RATE3}; // R17
    end else begin
      if (wr_thr)
        thresh_q <= thr_w;
      if (wr_cc)
        cont_cur_q <= w16;
      if (wr_sdly)
        stall_dly_q <= sdly_w;
      if (wr_gain)
        gain_q <= wdata[14:0]; // R4
      if (wr_phase)
        phase_q <= phase_w;
      if (wr_ofs)
        offset_q <= ofs_w;
      if (wr_ctrl)
        stall_en_q <= wdata[`HSH_CTRL_STALL_EN];
      if (start) begin
        index_sel_q <= wdata[`HSH_CTRL_INDEX]; // R11
        cw_q <= !offset_q[31]; // R9
      end
      for (int i = 0; i < 3; i++) begin
        if (wr && addr == `HSH_OFS_VEL1 + 8'(4 * i))
          steps_q[i].vel <= vel_w;
        if (wr && addr == `HSH_OFS_ACC1 + 8'(4 * i))
          steps_q[i].acc <= rate_w; // R16
        if (wr && addr == `HSH_OFS_DEC1 + 8'(4 * i))
          steps_q[i].dec <= rate_w; // R6
      end
    end
  end

  // interrupt status: a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_istat ? wdata[2:0] : 3'b000)) | evt;
      if (wr_imask)
        irq_mask_q <= wdata[2:0];
    end
  end

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (addr)
      `HSH_OFS_CTRL: rd_mux = {28'h0000000, stall_en_q, 1'b0, index_sel_q,
        1'b0};
      `HSH_OFS_STATUS: rd_mux = {26'h0000000, stall_flt_q, cw_q, homing_busy,
        state_q};
      `HSH_OFS_IRQ_STAT: rd_mux = {29'h00000000, irq_stat_q};
      `HSH_OFS_IRQ_MASK: rd_mux = {29'h00000000, irq_mask_q};
      `HSH_OFS_THRESH: rd_mux = {16'h0000, thresh_q};
      `HSH_OFS_CONT_CUR: rd_mux = {16'h0000, cont_cur_q};
      `HSH_OFS_STALL_DLY: rd_mux = {16'h0000, stall_dly_q};
      `HSH_OFS_HARM_GAIN: rd_mux = {17'h00000, gain_q};
      `HSH_OFS_HARM_PHASE: rd_mux = 32'(phase_q);
      `HSH_OFS_OFFSET: rd_mux = offset_q;
      default: begin
        for (int i = 0; i < 3; i++) begin
          if (addr == `HSH_OFS_VEL1 + 8'(4 * i))
            rd_mux = {16'h0000, steps_q[i].vel};
          if (addr == `HSH_OFS_ACC1 + 8'(4 * i))
            rd_mux = {16'h0000, steps_q[i].acc};
          if (addr == `HSH_OFS_DEC1 + 8'(4 * i))
            rd_mux = {16'h0000, steps_q[i].dec};
        end
      end
    endcase
  end

  // outputs: read data, ripple term, velocity command
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
      harm_comp <= 24'sh000000;
      vel_cmd <= '0;
    end else begin
      rdata_q <= rd ? rd_mux : 32'h00000000;
      harm_comp <= 24'($signed({1'b0, gain_q})) * 24'(phase_q); // R4 R5
      vel_cmd <= ramp_vel; // R13
    end
  end

  assign rdata = rdata_q;
  assign homing_busy = (state_q != HSH_IDLE);
  assign stall_fault = stall_flt_q;
  assign irq = |(irq_stat_q & irq_mask_q);
endmodule

// [hsh_monitor.sv]
// port checker for the homing sequencer
// assumes binding onto hsh_sequencer
`timescale 1ns/10ps
module hsh_monitor #(
  parameter int RAMP_TICK = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic stall_detect,
  input wire hsh_pkg::hsh_vel_t vel_cmd,
  input wire logic signed [23:0] harm_comp,
  input wire logic stall_fault,
  input wire logic homing_busy
);
  import hsh_pkg::*;
  // largest rate 32702 over a scale of 256
  localparam int MAX_STEP = 128;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_start_busy: assert property (
    wr && addr == 8'h00 && wdata[0] && !wdata[2] && !homing_busy
    |=> homing_busy) else $error("start not taken");
  a_moving_busy: assert property (
    vel_cmd != 0 |-> homing_busy) else $error("motion while idle");
  a_end_still: assert property (
    $fell(homing_busy) |-> vel_cmd == 0)
    else $error("ended while moving");
  a_ramp_hold: assert property (
    RAMP_TICK > 1 && $changed(vel_cmd) |=> $stable(vel_cmd))
    else $error("ramp too fast");
  a_ramp_step: assert property (
    vel_cmd - $past(vel_cmd) <= MAX_STEP
    && vel_cmd - $past(vel_cmd) >= -MAX_STEP)
    else $error("ramp step too large");
  a_vel_limit: assert property (
    vel_cmd <= 19047 && vel_cmd >= -19047) else $error("velocity range");
  a_harm_limit: assert property (
    harm_comp <= 4095875 && harm_comp >= -4095875)
    else $error("ripple term range");
  a_stall_clear: assert property (
    !stall_detect |=> ##[0:1] !stall_fault) else $error("fault stuck");
  a_stall_cause: assert property (
    $rose(stall_fault) |-> $past(stall_detect))
    else $error("fault without stall");
  c_start: cover property ($rose(homing_busy));
  c_done: cover property ($fell(homing_busy));
  c_stall: cover property ($rose(stall_fault));
  c_ccw: cover property (vel_cmd < 0);
endmodule

bind hsh_sequencer hsh_monitor #(.RAMP_TICK(RAMP_TICK)) u_hsh_monitor (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
  .stall_detect(stall_detect), .vel_cmd(vel_cmd), .harm_comp(harm_comp),
  .stall_fault(stall_fault), .homing_busy(homing_busy));

// [hsh_motor.sv]
// motor and encoder model on the drive side
// assumes vel_cmd from the sequencer, end stop set by the bench
`timescale 1ns/10ps
module hsh_motor (
  input wire logic clk,
  input wire logic rst,
  input wire hsh_pkg::hsh_vel_t vel_cmd,
  input wire logic stop_hit,
  input wire logic index_en,
  output logic [15:0] motor_current,
  output logic index_pulse,
  output logic step_tick
);
  import hsh_pkg::*;
  logic [1:0] div_q;
  logic [4:0] steps_q;
  wire logic moving = vel_cmd != 0;
  // current climbs at the end stop
  assign motor_current = stop_hit ? 16'h0100 : {11'h0, moving, 4'h0};
  assign step_tick = moving && div_q == 2'h3;
  assign index_pulse = index_en && step_tick && steps_q == 5'h1F;
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 2'h0;
      steps_q <= 5'h00;
    end else begin
      div_q <= moving ? div_q + 2'h1 : 2'h0;
      steps_q <= steps_q + {4'h0, step_tick};
    end
  end
endmodule

// [hard_stop_homing_sequencer_test.sv]
// self-checking bench for the homing sequencer
// assumes hsh_motor on the drive side
`timescale 1ns/10ps
module hard_stop_homing_sequencer_test;
  import hsh_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stall_detect = 1'b0;
  logic stop_hit = 1'b0;
  logic index_en = 1'b0;
  logic seen_pos = 1'b0;
  logic seen_neg = 1'b0;
  logic [31:0] rdata;
  logic [15:0] motor_current;
  logic index_pulse, step_tick, stall_fault, homing_busy, irq;
  hsh_vel_t vel_cmd;
  logic signed [23:0] harm_comp;
  int n_fail = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (vel_cmd > 0) seen_pos <= 1'b1;
    if (vel_cmd < 0) seen_neg <= 1'b1;
  end
  hsh_sequencer #(.MS_CYCLES(10), .STEP_TIMEOUT_MS(50), .RAMP_TICK(2))
    u_hsh_sequencer (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .motor_current(motor_current),
    .index_pulse(index_pulse), .stall_detect(stall_detect),
    .step_tick(step_tick), .vel_cmd(vel_cmd), .harm_comp(harm_comp),
    .stall_fault(stall_fault), .homing_busy(homing_busy), .irq(irq));
  hsh_motor u_hsh_motor (.clk(clk), .rst(rst), .vel_cmd(vel_cmd),
    .stop_hit(stop_hit), .index_en(index_en),
    .motor_current(motor_current), .index_pulse(index_pulse),
    .step_tick(step_tick));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    logic [7:0] ra [14] = '{8'h10, 8'h14, 8'h18, 8'h24, 8'h28, 8'h2C,
      8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h7C};
    logic [15:0] ev [14] = '{16'h64, 16'hC8, 16'h3E8, 16'h94D, 16'h4A6,
      16'h77, 16'h257, 16'h257, 16'h3C, 16'h257, 16'h257, 16'h3C,
      16'h7D0, 16'h0};
    logic [31:0] d;
    for (int i = 0; i < 14; i++) begin
      rd_reg(ra[i], d);
      chk(d, {16'h0, ev[i]});
    end
    $display("test reset values done");
  endtask
  task automatic t_clamp();
    logic [7:0] ca [11] = '{8'h10, 8'h10, 8'h18, 8'h18, 8'h1C, 8'h20,
      8'h20, 8'h3C, 8'h3C, 8'h24, 8'h48};
    logic [31:0] cw [11] = '{32'h0, 32'h12C, 32'h0, 32'h9C40, 32'hFFFF,
      32'hC8, 32'hFFFFFF38, 32'h0, 32'hFFFF, 32'hFFFF, 32'h80000000};
    logic [31:0] ce [11] = '{32'h1, 32'hC8, 32'h1, 32'h7D00, 32'h7FFF,
      32'h7D, 32'hFFFFFF83, 32'h1, 32'h7FBE, 32'h4A67, 32'h80000001};
    logic [31:0] d;
    for (int i = 0; i < 11; i++) begin
      wr_reg(ca[i], cw[i]);
      rd_reg(ca[i], d);
      chk(d, ce[i]);
    end
    wr_reg(8'h1C, 32'h64);
    wr_reg(8'h20, 32'hFFFFFFFB);
    repeat (4) tick();
    chk({8'h00, harm_comp}, 32'h00FFFE0C);
    $display("test clamps done");
  endtask
  task automatic t_home(input logic idx, input logic ien,
      input logic [31:0] off, input logic [31:0] est);
    logic [31:0] d;
    @(posedge clk);
    index_en <= ien;
    wr_reg(8'h48, off);
    seen_pos = 1'b0;
    seen_neg = 1'b0;
    wr_reg(8'h00, {30'h0, idx, 1'b1});
    #1 chk(homing_busy, 1'b1);
    for (int i = 0; i < 200 && vel_cmd == 0; i++) tick();
    chk(vel_cmd[17], off[31]);
    chk(vel_cmd <= 100 && vel_cmd >= -100, 1'b1);
    @(posedge clk);
    stop_hit <= 1'b1;
    for (int i = 0; i < 4000 && homing_busy !== 1'b0; i++) tick();
    @(posedge clk);
    stop_hit <= 1'b0;
    rd_reg(8'h08, d);
    chk(d, est);
    if (est == 32'h1) chk(seen_pos & seen_neg, 1'b1);
    chk(irq, 1'b1);
    wr_reg(8'h08, 32'h7);
    tick();
    chk(irq, 1'b0);
    $display("test homing done");
  endtask
  task automatic t_abort();
    logic [31:0] d;
    wr_reg(8'h00, 32'h1);
    wr_reg(8'h00, 32'h4);
    for (int i = 0; i < 4000 && homing_busy !== 1'b0; i++) tick();
    rd_reg(8'h08, d);
    chk(d, 32'h2);
    chk(vel_cmd, 32'h0);
    wr_reg(8'h08, 32'h7);
    $display("test abort done");
  endtask
  task automatic t_stall();
    logic [31:0] d;
    int n;
    wr_reg(8'h18, 32'h3);
    wr_reg(8'h00, 32'h8);
    stall_detect <= 1'b1;
    for (n = 0; n < 100 && stall_fault !== 1'b1; n++) tick();
    chk(n >= 20 && n <= 31, 1'b1);
    rd_reg(8'h08, d);
    chk(d, 32'h4);
    @(posedge clk);
    stall_detect <= 1'b0;
    repeat (2) tick();
    chk(stall_fault, 1'b0);
    $display("test stall done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_clamp();
    for (int i = 0; i < 9; i++) begin
      wr_reg(8'h24 + 8'(4 * i), i < 3 ? 32'h64 : 32'h7FBE);
    end
    wr_reg(8'h10, 32'h32);
    wr_reg(8'h0C, 32'h7);
    t_home(1'b0, 1'b0, 32'h14, 32'h1);
    t_home(1'b1, 1'b1, 32'hFFFFFFEC, 32'h1);
    t_home(1'b1, 1'b0, 32'h14, 32'h2);
    t_abort();
    t_stall();
    finish_test();
  end
  initial begin
    #40000;
    n_fail++;
    finish_test();
  end
endmodule
